/* File: logic/bfp_consts.svh */
// Constants of the bidirectional FIFO port block: sizes, offsets, field positions.
// Assumes inclusion by bare name from the block's design files.
`ifndef BFP_CONSTS_SVH
`define BFP_CONSTS_SVH

// ----------------------------------------
// Sizes
// ----------------------------------------
`define BFP_DATA_W 36
`define BFP_QUEUE_DEPTH 1024
`define BFP_STAGE_DEPTH 4

// ----------------------------------------
// Almost-flag offsets
// ----------------------------------------
`define BFP_OFS_PRESET_A 8
`define BFP_OFS_PRESET_B 16
`define BFP_OFS_PRESET_C 64
`define BFP_OFS_DEFAULT 8

// ----------------------------------------
// Sampled pin vector layout
// ----------------------------------------
`define BFP_PV_CTL_W 4
`define BFP_PV_DIR 0
`define BFP_PV_EN 1
`define BFP_PV_SEL 2
`define BFP_PV_CLK 3
`define BFP_MISC_QRST 0
`define BFP_MISC_MODE 2
`define BFP_MISC_FSLO 3
`define BFP_MISC_FSHI 4
`define BFP_MISC_W 5
`define BFP_SYNC_DEPTH 3

`endif

/* File: logic/bfp_fifo.sv */
// Small staging FIFO with valid/ready on both sides and a word count.
// Assumes one clock; i_clear empties it synchronously.
`timescale 1ns/100ps
module bfp_fifo #(
    parameter int WIDTH = 36,
    parameter int DEPTH = 4
) (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_clear,
    input wire logic i_in_valid,
    output logic o_in_ready,
    input wire logic [WIDTH-1:0] i_in_data,
    output logic o_out_valid,
    input wire logic i_out_ready,
    output logic [WIDTH-1:0] o_out_data,
    output logic [$clog2(DEPTH+1)-1:0] o_count
);
    localparam int AW = $clog2(DEPTH);
    localparam int CW = $clog2(DEPTH+1);
    localparam logic [CW-1:0] FULL_CNT = CW'(DEPTH);

    logic [WIDTH-1:0] buf_reg [0:DEPTH-1];
    logic [AW-1:0] wp_reg, wp_next, rp_reg, rp_next;
    logic [CW-1:0] cnt_reg, cnt_next;
    logic push, pop;

    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_chk
        $error("bfp_fifo depth must be a power of two, at least two");
    end

    assign o_in_ready = (cnt_reg != FULL_CNT);
    assign o_out_valid = (cnt_reg != '0);
    assign o_out_data = buf_reg[rp_reg];
    assign o_count = cnt_reg;
    assign push = i_in_valid && o_in_ready;
    assign pop = o_out_valid && i_out_ready;

    always_comb begin
        wp_next = wp_reg;
        rp_next = rp_reg;
        cnt_next = cnt_reg;
        if (i_clear) begin
            wp_next = '0;
            rp_next = '0;
            cnt_next = '0;
        end else begin
            wp_next = push ? wp_reg + AW'(1) : wp_reg;
            rp_next = pop ? rp_reg + AW'(1) : rp_reg;
            cnt_next = cnt_reg + CW'(push) - CW'(pop);
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            wp_reg <= '0;
            rp_reg <= '0;
            cnt_reg <= '0;
        end else begin
            wp_reg <= wp_next;
            rp_reg <= rp_next;
            cnt_reg <= cnt_next;
        end
        if (push && !i_clear) begin
            buf_reg[wp_reg] <= i_in_data;
        end
    end
endmodule

/* File: logic/bfp_mem.sv */
// Word memory of one queue: one write port, one read port, registered read data.
// Assumes the caller never reads a word in the cycle it is written.
`timescale 1ns/100ps
module bfp_mem #(
    parameter int WIDTH = 36,
    parameter int DEPTH = 1024
) (
    input wire logic i_clk,
    input wire logic i_wr_en,
    input wire logic [$clog2(DEPTH)-1:0] i_wr_addr,
    input wire logic [WIDTH-1:0] i_wr_data,
    input wire logic i_rd_en,
    input wire logic [$clog2(DEPTH)-1:0] i_rd_addr,
    output logic [WIDTH-1:0] o_rd_data
);
    logic [WIDTH-1:0] mem_reg [0:DEPTH-1];

    if (DEPTH < 2) begin : g_chk
        $error("bfp_mem needs at least two words");
    end

    // No reset on the array: it is large and the pointers define what is valid
    always_ff @(posedge i_clk) begin
        if (i_wr_en) begin
            mem_reg[i_wr_addr] <= i_wr_data;
        end
        if (i_rd_en) begin
            o_rd_data <= mem_reg[i_rd_addr];
        end
    end
endmodule

/* File: logic/bfp_pkg.sv */
// Types of the bidirectional FIFO port block.
// Assumes nothing of its surroundings.
package bfp_pkg;

    // ----------------------------------------
    // Read side sequencing
    // ----------------------------------------
    typedef enum logic [1:0] {
        BFP_RD_IDLE = 2'b01,
        BFP_RD_FETCH = 2'b10
    } bfp_rd_state_t;

    // ----------------------------------------
    // Timing mode
    // ----------------------------------------
    typedef enum logic {
        BFP_STANDARD = 1'b0,
        BFP_FALL_THROUGH = 1'b1
    } bfp_mode_t;

endpackage

/* File: logic/bfp_top.sv */
// Port-side control and flags of a bidirectional queue pair (left->right forward, right->left reverse).
// Assumes port clocks and pins are sampled by i_clk; each port clock level lasts at least 4 i_clk cycles.
`timescale 1ns/100ps
`include "bfp_consts.svh"

// What this block does
// - Left almost-empty low when reverse words <= threshold
// - Right almost-empty low when forward words <= threshold
// - Left almost-full low when forward free <= threshold
// - Right almost-full low when reverse free <= threshold
// - Mode taken from select pin during queue reset
// - Both port clocks run; unrelated or coincident
// - Left flags change only on left clock rise
// - Right flags change only on right clock rise
// - Left transfers need select low; else bus floats
// - Right transfers need select low; else bus floats
// - Left transfers need left enable high
// - Right transfers need right enable high
// - Left empty flag, or output ready in fall-through
// - Right empty flag, or output ready in fall-through
// - Left full flag, or input ready in fall-through
// - Right full flag, or input ready in fall-through
// - 36-bit ports; writes one queue, reads other
// - Queue reset clears pointers and output register
// - Reset rise latches preset offset selection
module bfp_top #(
    parameter int DW = `BFP_DATA_W,
    parameter int DEPTH = `BFP_QUEUE_DEPTH,
    parameter int SDEPTH = `BFP_STAGE_DEPTH
) (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_left_port_clock,
    input wire logic i_left_port_select_n,
    input wire logic i_left_port_enable,
    input wire logic i_left_direction_select,
    input wire logic [DW-1:0] i_left_data_bus,
    output logic [DW-1:0] o_left_data_bus,
    output logic o_left_data_bus_oe,
    output logic o_left_empty_or_out_ready,
    output logic o_left_full_or_in_ready,
    output logic o_left_almost_empty_n,
    output logic o_left_almost_full_n,
    input wire logic i_right_port_clock,
    input wire logic i_right_port_select_n,
    input wire logic i_right_port_enable,
    input wire logic i_right_direction_select,
    input wire logic [DW-1:0] i_right_data_bus,
    output logic [DW-1:0] o_right_data_bus,
    output logic o_right_data_bus_oe,
    output logic o_right_empty_or_out_ready,
    output logic o_right_full_or_in_ready,
    output logic o_right_almost_empty_n,
    output logic o_right_almost_full_n,
    input wire logic i_fall_through_mode_select,
    input wire logic i_offset_preset_sel_lo,
    input wire logic i_offset_preset_sel_hi,
    input wire logic i_forward_queue_reset_n,
    input wire logic i_reverse_queue_reset_n
);
    // ----------------------------------------
    // Sizes and helpers
    // ----------------------------------------
    localparam int AW = $clog2(DEPTH);
    localparam int CW = $clog2(DEPTH+1);
    localparam int SCW = $clog2(SDEPTH+1);
    localparam int PV_W = DW + `BFP_PV_CTL_W;
    localparam int MB = 2 * PV_W;
    localparam int SV_W = MB + `BFP_MISC_W;
    localparam logic [CW-1:0] FULL_CNT = CW'(DEPTH);

    if (DEPTH < 2 * `BFP_OFS_PRESET_C || (DEPTH & (DEPTH - 1)) != 0) begin : g_chk
        $error("bfp_top depth must be a power of two, at least twice the largest preset");
    end

    function automatic logic [CW-1:0] ofs_sel(input logic hi, input logic lo);
        logic [CW-1:0] v;
        case ({hi, lo})
            2'b01: v = CW'(`BFP_OFS_PRESET_A);
            2'b10: v = CW'(`BFP_OFS_PRESET_B);
            2'b11: v = CW'(`BFP_OFS_PRESET_C);
            default: v = CW'(`BFP_OFS_DEFAULT);
        endcase
        return v;
    endfunction

    // ----------------------------------------
    // Pin sampling
    // ----------------------------------------
    // A bit changes only once the second and third stages agree, so a glitch shorter than a cycle is dropped
    logic [SV_W-1:0] pins, s1_reg, s2_reg, s3_reg, ag_reg, ag_next;

    assign pins = {i_offset_preset_sel_hi, i_offset_preset_sel_lo, i_fall_through_mode_select,
                   i_reverse_queue_reset_n, i_forward_queue_reset_n,
                   i_right_port_clock, i_right_port_select_n, i_right_port_enable, i_right_direction_select,
                   i_right_data_bus,
                   i_left_port_clock, i_left_port_select_n, i_left_port_enable, i_left_direction_select,
                   i_left_data_bus};

    always_comb begin
        ag_next = (s3_reg & ~(s2_reg ^ s3_reg)) | (ag_reg & (s2_reg ^ s3_reg));
    end

    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            s1_reg <= '0;
            s2_reg <= '0;
            s3_reg <= '0;
            ag_reg <= '0;
        end else begin
            s1_reg <= pins;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
            ag_reg <= ag_next;
        end
    end

    // ----------------------------------------
    // Port decode (index 0 left, 1 right; queue 0 forward, 1 reverse)
    // ----------------------------------------
    logic [1:0] pedge, psel, pwr, wr_req, rd_req, qrst, qrst_rise;
    logic [DW-1:0] pdata [0:1];

    always_comb begin
        for (int p = 0; p < 2; p++) begin
            pedge[p] = ag_next[p*PV_W + DW + `BFP_PV_CLK] && !ag_reg[p*PV_W + DW + `BFP_PV_CLK];
            psel[p] = ag_next[p*PV_W + DW + `BFP_PV_SEL];
            pdata[p] = ag_next[p*PV_W +: DW];
            pwr[p] = ag_next[p*PV_W + DW + `BFP_PV_DIR] ^ (p == 1);
            wr_req[p] = pedge[p] && !psel[p] && ag_next[p*PV_W + DW + `BFP_PV_EN] && pwr[p];
            rd_req[p] = pedge[p] && !psel[p] && ag_next[p*PV_W + DW + `BFP_PV_EN] && !pwr[p];
            qrst[p] = !ag_next[MB + `BFP_MISC_QRST + p];
            qrst_rise[p] = ag_next[MB + `BFP_MISC_QRST + p] && !ag_reg[MB + `BFP_MISC_QRST + p];
        end
    end

    // ----------------------------------------
    // Mode and offsets
    // ----------------------------------------
    bfp_pkg::bfp_mode_t mode_reg, mode_next;
    logic [CW-1:0] ofs_reg [0:1];
    logic [CW-1:0] ofs_next [0:1];
    logic fwft;

    assign fwft = (mode_reg == bfp_pkg::BFP_FALL_THROUGH);

    always_comb begin
        mode_next = mode_reg;
        if (qrst != 2'b00) begin
            mode_next = ag_next[MB + `BFP_MISC_MODE] ? bfp_pkg::BFP_STANDARD : bfp_pkg::BFP_FALL_THROUGH;
        end
        for (int q = 0; q < 2; q++) begin
            ofs_next[q] = ofs_reg[q];
            if (qrst_rise[q]) begin
                ofs_next[q] = ofs_sel(ag_next[MB + `BFP_MISC_FSHI], ag_next[MB + `BFP_MISC_FSLO]);
            end
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            mode_reg <= bfp_pkg::BFP_STANDARD;
            ofs_reg[0] <= CW'(`BFP_OFS_DEFAULT);
            ofs_reg[1] <= CW'(`BFP_OFS_DEFAULT);
        end else begin
            mode_reg <= mode_next;
            ofs_reg[0] <= ofs_next[0];
            ofs_reg[1] <= ofs_next[1];
        end
    end

    // ----------------------------------------
    // Queue pointers, counts and read sequencing
    // ----------------------------------------
    // Queue q is written by port q and read by port 1-q
    logic [AW-1:0] wptr_reg [0:1];
    logic [AW-1:0] wptr_next [0:1];
    logic [AW-1:0] rptr_reg [0:1];
    logic [AW-1:0] rptr_next [0:1];
    logic [CW-1:0] mcnt_reg [0:1];
    logic [CW-1:0] mcnt_next [0:1];
    logic [CW-1:0] tot [0:1];
    logic [CW-1:0] ae_words [0:1];
    logic [DW-1:0] out_reg [0:1];
    logic [DW-1:0] out_next [0:1];
    logic [DW-1:0] mem_rdata [0:1];
    logic [DW-1:0] stg_data [0:1];
    logic [SCW-1:0] stg_cnt [0:1];
    bfp_pkg::bfp_rd_state_t rst_reg [0:1];
    bfp_pkg::bfp_rd_state_t rst_next [0:1];
    logic [1:0] ov_reg, ov_next, full, wr_take, stg_rdy, stg_vld, drain, fetch, qrd;

    always_comb begin
        for (int q = 0; q < 2; q++) begin
            tot[q] = mcnt_reg[q] + CW'(stg_cnt[q]);
            ae_words[q] = tot[q] + CW'(fwft && ov_reg[q]);
            full[q] = (tot[q] == FULL_CNT);
            wr_take[q] = wr_req[q] && !full[q] && stg_rdy[q];
            drain[q] = stg_vld[q] && (mcnt_reg[q] != FULL_CNT);
            qrd[q] = rd_req[1-q];
            fetch[q] = 1'b0;
            wptr_next[q] = drain[q] ? wptr_reg[q] + AW'(1) : wptr_reg[q];
            rptr_next[q] = rptr_reg[q];
            ov_next[q] = ov_reg[q];
            out_next[q] = out_reg[q];
            rst_next[q] = rst_reg[q];
            case (rst_reg[q])
                bfp_pkg::BFP_RD_IDLE: begin
                    // Empty reads are dropped; in fall-through an idle output register prefetches on its own
                    if (mcnt_reg[q] != '0) begin
                        fetch[q] = fwft ? (!ov_reg[q] || qrd[q]) : qrd[q];
                    end
                    if (fwft && qrd[q] && ov_reg[q] && !fetch[q]) begin
                        ov_next[q] = 1'b0;
                    end
                    if (fetch[q]) begin
                        rptr_next[q] = rptr_reg[q] + AW'(1);
                        rst_next[q] = bfp_pkg::BFP_RD_FETCH;
                    end
                end
                bfp_pkg::BFP_RD_FETCH: begin
                    out_next[q] = mem_rdata[q];
                    ov_next[q] = 1'b1;
                    rst_next[q] = bfp_pkg::BFP_RD_IDLE;
                end
                default: begin
                    rst_next[q] = bfp_pkg::BFP_RD_IDLE;
                end
            endcase
            mcnt_next[q] = mcnt_reg[q] + CW'(drain[q]) - CW'(fetch[q]);
            if (qrst[q]) begin
                wptr_next[q] = '0;
                rptr_next[q] = '0;
                mcnt_next[q] = '0;
                ov_next[q] = 1'b0;
                out_next[q] = '0;
                rst_next[q] = bfp_pkg::BFP_RD_IDLE;
            end
        end
    end

    always_ff @(posedge i_clk) begin
        for (int q = 0; q < 2; q++) begin
            if (!i_rst_n) begin
                wptr_reg[q] <= '0;
                rptr_reg[q] <= '0;
                mcnt_reg[q] <= '0;
                out_reg[q] <= '0;
                rst_reg[q] <= bfp_pkg::BFP_RD_IDLE;
                ov_reg[q] <= 1'b0;
            end else begin
                wptr_reg[q] <= wptr_next[q];
                rptr_reg[q] <= rptr_next[q];
                mcnt_reg[q] <= mcnt_next[q];
                out_reg[q] <= out_next[q];
                rst_reg[q] <= rst_next[q];
                ov_reg[q] <= ov_next[q];
            end
        end
    end

    // ----------------------------------------
    // Storage: staging FIFO in front of each queue memory
    // ----------------------------------------
    for (genvar q = 0; q < 2; q++) begin : g_q
        bfp_fifo #(.WIDTH(DW), .DEPTH(SDEPTH)) u_stage (
            .i_clk(i_clk),
            .i_rst_n(i_rst_n),
            .i_clear(qrst[q]),
            .i_in_valid(wr_take[q]),
            .o_in_ready(stg_rdy[q]),
            .i_in_data(pdata[q]),
            .o_out_valid(stg_vld[q]),
            .i_out_ready(drain[q]),
            .o_out_data(stg_data[q]),
            .o_count(stg_cnt[q])
        );
        bfp_mem #(.WIDTH(DW), .DEPTH(DEPTH)) u_mem (
            .i_clk(i_clk),
            .i_wr_en(drain[q]),
            .i_wr_addr(wptr_reg[q]),
            .i_wr_data(stg_data[q]),
            .i_rd_en(fetch[q]),
            .i_rd_addr(rptr_reg[q]),
            .o_rd_data(mem_rdata[q])
        );
    end

    // ----------------------------------------
    // Flags (bit p belongs to port p)
    // ----------------------------------------
    // Flags move only on their own port's clock rise, so they lag the counts by up to one port cycle
    logic [1:0] efor_reg, efor_next, ffir_reg, ffir_next, ae_reg, ae_next, af_reg, af_next;

    always_comb begin
        for (int p = 0; p < 2; p++) begin
            efor_next[p] = efor_reg[p];
            ffir_next[p] = ffir_reg[p];
            ae_next[p] = ae_reg[p];
            af_next[p] = af_reg[p];
            if (pedge[p]) begin
                efor_next[p] = !qrst[1-p] && (fwft ? ov_reg[1-p] : (tot[1-p] != '0));
                ffir_next[p] = !qrst[p] && !full[p];
                ae_next[p] = !qrst[1-p] && (ae_words[1-p] > ofs_reg[1-p]);
                af_next[p] = qrst[p] || ((FULL_CNT - tot[p]) > ofs_reg[p]);
            end
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            efor_reg <= 2'h0;
            ffir_reg <= 2'h0;
            ae_reg <= 2'h0;
            af_reg <= 2'h3;
        end else begin
            efor_reg <= efor_next;
            ffir_reg <= ffir_next;
            ae_reg <= ae_next;
            af_reg <= af_next;
        end
    end

    // ----------------------------------------
    // Outputs
    // ----------------------------------------
    assign o_left_data_bus = out_reg[1];
    assign o_right_data_bus = out_reg[0];
    assign o_left_data_bus_oe = !psel[0] && !pwr[0];
    assign o_right_data_bus_oe = !psel[1] && !pwr[1];
    assign o_left_empty_or_out_ready = efor_reg[0];
    assign o_right_empty_or_out_ready = efor_reg[1];
    assign o_left_full_or_in_ready = ffir_reg[0];
    assign o_right_full_or_in_ready = ffir_reg[1];
    assign o_left_almost_empty_n = ae_reg[0];
    assign o_right_almost_empty_n = ae_reg[1];
    assign o_left_almost_full_n = af_reg[0];
    assign o_right_almost_full_n = af_reg[1];

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);

    a_left_ae_level: assert property (
        pedge[0] && !qrst[1] |=> o_left_almost_empty_n == ($past(ae_words[1]) > $past(ofs_reg[1])))
        else $error("left almost-empty disagrees with reverse word count");
    a_right_ae_level: assert property (
        pedge[1] && !qrst[0] |=> o_right_almost_empty_n == ($past(ae_words[0]) > $past(ofs_reg[0])))
        else $error("right almost-empty disagrees with forward word count");
    a_left_af_level: assert property (
        pedge[0] && !qrst[0] |=> o_left_almost_full_n == ((FULL_CNT - $past(tot[0])) > $past(ofs_reg[0])))
        else $error("left almost-full disagrees with forward free space");
    a_right_af_level: assert property (
        pedge[1] && !qrst[1] |=> o_right_almost_full_n == ((FULL_CNT - $past(tot[1])) > $past(ofs_reg[1])))
        else $error("right almost-full disagrees with reverse free space");
    a_mode_capture: assert property (
        qrst != 2'b00 |=> fwft == !$past(ag_next[MB + `BFP_MISC_MODE]))
        else $error("mode not taken during queue reset");
    a_left_flag_hold: assert property (
        !pedge[0] |=> $stable({efor_reg[0], ffir_reg[0], ae_reg[0], af_reg[0]}))
        else $error("left flag moved without a left clock rise");
    a_right_flag_hold: assert property (
        !pedge[1] |=> $stable({efor_reg[1], ffir_reg[1], ae_reg[1], af_reg[1]}))
        else $error("right flag moved without a right clock rise");
    a_left_sel_gate: assert property (
        psel[0] && !qrst[0] |=> tot[0] <= $past(tot[0]))
        else $error("left write taken while deselected");
    a_full_refuse: assert property (
        wr_req[0] && full[0] && !qrst[0] |=> tot[0] <= $past(tot[0]))
        else $error("forward queue grew while full");
    a_reset_clear: assert property (
        qrst[0] |=> mcnt_reg[0] == '0 && out_reg[0] == '0 && wptr_reg[0] == '0)
        else $error("forward queue not cleared by reset");
    a_preset_latch: assert property (
        qrst_rise[1] && ag_next[MB + `BFP_MISC_FSHI] && ag_next[MB + `BFP_MISC_FSLO]
        |=> ofs_reg[1] == CW'(`BFP_OFS_PRESET_C))
        else $error("preset offset not latched at reset release");
    a_fall_through: assert property (
        fwft && !qrst[0] && rst_reg[0] == bfp_pkg::BFP_RD_IDLE && !ov_reg[0] && mcnt_reg[0] != '0
        ##1 !qrst[0] |=> ov_reg[0])
        else $error("first word did not fall through");

    c_left_write: cover property (wr_take[0]);
    c_right_read: cover property (fetch[0] && rd_req[1]);
    c_forward_full: cover property (full[0]);
    c_fall_through: cover property (fwft && $rose(ov_reg[1]));
endmodule

/* File: verification/bfp_port_model.sv */
// Far-side controller model: a free-running port clock and the resolved port bus wire.
// Assumes the bench drives the port pins; the device's output enable has priority.
`timescale 1ns/100ps
module bfp_port_model #(parameter real HALF = 50.0, parameter real PHASE = 0.0) (
    input wire logic i_oe,
    input wire logic [35:0] i_dev_data,
    input wire logic i_drv,
    input wire logic [35:0] i_drv_data,
    output logic o_port_clock,
    output logic [35:0] o_bus
);
    initial begin
        o_port_clock = 1'b0;
        #PHASE;
        forever #HALF o_port_clock = ~o_port_clock;
    end
    // A released bus shows the inverse of the last word, so a stale sample shows up
    assign o_bus = i_oe ? i_dev_data : (i_drv ? i_drv_data : ~i_drv_data);
endmodule

/* File: verification/bfp_top_bench.sv */
// Self-checking bench of bfp_top: both ports driven by tasks, flags and data compared.
// Assumes bfp_port_model supplies the two unrelated port clocks and the bus wires.
`timescale 1ns/100ps
module bfp_top_bench;
    logic i_clk, i_rst_n, mode, fs_lo, fs_hi, fq_n, rq_n;
    logic [1:0] sn, en, dir, drv;
    logic [35:0] dd [2];
    wire lclk, rclk, l_oe, r_oe, l_emp, l_ful, l_ae, l_af, r_emp, r_ful, r_ae, r_af;
    wire [35:0] l_bus, r_bus, l_q, r_q;
    wire [1:0] pc = {rclk, lclk};
    wire [7:0] fl = {l_emp, l_ful, l_ae, l_af, r_emp, r_ful, r_ae, r_af};
    int n_fail = 0;
    int samples_checked = 0;
    bfp_port_model #(.HALF(50.0), .PHASE(0.0)) i_lm (.i_oe(l_oe), .i_dev_data(l_q), .i_drv(drv[0]),
        .i_drv_data(dd[0]), .o_port_clock(lclk), .o_bus(l_bus));
    bfp_port_model #(.HALF(70.0), .PHASE(13.0)) i_rm (.i_oe(r_oe), .i_dev_data(r_q), .i_drv(drv[1]),
        .i_drv_data(dd[1]), .o_port_clock(rclk), .o_bus(r_bus));
    // Smallest legal depth, so the full and almost-full scenario stays short
    bfp_top #(.DEPTH(128)) i_dut (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_left_port_clock(lclk),
        .i_left_port_select_n(sn[0]),
        .i_left_port_enable(en[0]), .i_left_direction_select(dir[0]), .i_left_data_bus(l_bus), .o_left_data_bus(l_q),
        .o_left_data_bus_oe(l_oe), .o_left_empty_or_out_ready(l_emp), .o_left_full_or_in_ready(l_ful),
        .o_left_almost_empty_n(l_ae), .o_left_almost_full_n(l_af), .i_right_port_clock(rclk),
        .i_right_port_select_n(sn[1]), .i_right_port_enable(en[1]), .i_right_direction_select(dir[1]),
        .i_right_data_bus(r_bus), .o_right_data_bus(r_q), .o_right_data_bus_oe(r_oe),
        .o_right_empty_or_out_ready(r_emp), .o_right_full_or_in_ready(r_ful), .o_right_almost_empty_n(r_ae),
        .o_right_almost_full_n(r_af), .i_fall_through_mode_select(mode), .i_offset_preset_sel_lo(fs_lo),
        .i_offset_preset_sel_hi(fs_hi), .i_forward_queue_reset_n(fq_n), .i_reverse_queue_reset_n(rq_n));
    task automatic stop_test();
        if (n_fail == 0 && samples_checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    task automatic chk(input logic [35:0] got, input logic [35:0] exp);
        samples_checked++;
        if (got !== exp) begin
            n_fail++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge i_clk);
        #1;
    endtask
    // Pins change just after the first i_clk rise that follows the port clock fall, so they stand well around the rise
    task automatic xfer(input bit s, input logic s_n, input logic e, input logic wr, input logic [35:0] d);
        wait (pc[s]);
        wait (!pc[s]);
        tick(1);
        sn[s] = s_n;
        en[s] = e;
        dir[s] = wr ^ s;
        drv[s] = wr;
        dd[s] = d;
        wait (pc[s]);
        wait (!pc[s]);
        tick(1);
        sn[s] = 1'b1;
        drv[s] = 1'b0;
    endtask
    task automatic qrst(input logic m, input logic hi, input logic lo);
        {fq_n, rq_n, mode, fs_hi, fs_lo} = {2'b00, m, hi, lo};
        tick(80);
        {fq_n, rq_n} = 2'b11;
        tick(40);
    endtask
    task automatic t_gate();
        qrst(1'b1, 1'b0, 1'b0);
        chk(fl, 8'h55);
        xfer(0, 1'b1, 1'b1, 1'b1, 36'h0_dead_0001);
        xfer(0, 1'b0, 1'b0, 1'b1, 36'h0_dead_0002);
        xfer(0, 1'b0, 1'b1, 1'b1, 36'ha_5a5a_5a5a);
        dir[1] = 1'b1;
        tick(36);
        chk(fl, 8'h5d);
        chk(r_oe, 1'b0);
        xfer(1, 1'b0, 1'b0, 1'b0, 36'h0);
        tick(36);
        chk(r_q, 36'h0);
        for (int i = 0; i < 2; i++) begin
            xfer(1, 1'b0, 1'b1, 1'b0, 36'h0);
            tick(36);
            chk(r_q, 36'ha_5a5a_5a5a);
        end
        chk(fl, 8'h55);
    endtask
    task automatic t_count();
        for (int i = 0; i < 9; i++) begin
            if (i == 8) begin
                tick(36);
                chk(fl, 8'h5d);
            end
            xfer(0, 1'b0, 1'b1, 1'b1, 36'h1_0000_0000 + i);
        end
        tick(36);
        chk(fl, 8'h5f);
        for (int i = 0; i < 9; i++) begin
            xfer(1, 1'b0, 1'b1, 1'b0, 36'h0);
            tick(36);
            chk(r_q, 36'h1_0000_0000 + i);
        end
    endtask
    // Nine words sit above the 8 offset but below the 16 and 64 offsets
    task automatic t_rev(input logic m, input logic hi, input logic lo);
        qrst(m, hi, lo);
        for (int i = 0; i < 9; i++) begin
            xfer(1, 1'b0, 1'b1, 1'b1, 36'h2_0000_0000 + i);
        end
        tick(36);
        chk(fl, hi ? 8'hd5 : 8'hf5);
        chk(l_q, m ? 36'h0 : 36'h2_0000_0000);
        {sn[0], en[0], dir[0]} = 3'b000;
        tick(6);
        chk(l_oe, 1'b1);
        xfer(0, 1'b0, 1'b1, 1'b0, 36'h0);
        tick(36);
        chk(l_q, m ? 36'h2_0000_0000 : 36'h2_0000_0001);
        chk(l_oe, 1'b0);
    endtask
    // Queue depth is 128, so the last write and the last read are refused
    task automatic t_full();
        for (int i = 0; i < 129; i++) begin
            if (i == 119 || i == 120 || i == 128) begin
                tick(36);
                chk(fl, i == 119 ? 8'h5f : (i == 120 ? 8'h4f : 8'h0f));
            end
            xfer(0, 1'b0, 1'b1, 1'b1, 36'h3_0000_0000 + i);
        end
        for (int i = 0; i < 129; i++) begin
            xfer(1, 1'b0, 1'b1, 1'b0, 36'h0);
            chk(r_q, 36'h3_0000_0000 + (i < 128 ? i : 127));
        end
    endtask
    initial begin
        i_clk = 1'b0;
        forever #5 i_clk = ~i_clk;
    end
    initial begin
        i_rst_n = 1'b0;
        {sn, en, dir, drv} = 8'hc0;
        dd = '{36'h0, 36'h0};
        {mode, fs_lo, fs_hi, fq_n, rq_n} = 5'h10;
        tick(8);
        i_rst_n = 1'b1;
        tick(4);
        t_gate();
        t_count();
        t_full();
        t_rev(1'b1, 1'b1, 1'b0);
        t_rev(1'b0, 1'b1, 1'b1);
        t_rev(1'b1, 1'b0, 1'b1);
        stop_test();
    end
    initial begin
        #300000;
        n_fail++;
        stop_test();
    end
endmodule
